// >>> shared/ubp_pkg.sv
// Functional notes
// - Latch sequence and phase values every 5 ms
// - Ratio mode needs minimum load on all phases
// - Forced status applies only with forcing enabled
// - Static choice: negative per unit or ratio
// - Pick up above level; compute measured/set ratio
// - Release below 97 % of level
// - Negative level in 0.01 In, default 0.2
// - Ratio level in 0.01 %, default 20 %
// - Levels and timing may change while running
// - Sample block input at each cycle start
// - Pick-up without block gives start, timing
// - Pick-up with block gives blocked only
// - Block after start drops start, resets timing
// - Instant mode trips with start
// - Definite mode trips after set delay
// - Inverse mode delay from level and measurement
// - Squared-law delay k over squared difference
// - Report state, ratios, expected and remaining time
// - Timestamped masked on/off events per stage
// - Clearable start, trip, blocked counters
// - Record on-events into twelve-entry ring
// - Record holds time, history, sequences, group
package ubp_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int CYCLE_TIME_NS = 5000000;
    localparam int CYCLE_CLKS    = CYCLE_TIME_NS / CLK_PERIOD_NS;
    localparam int CYCLE_TIME_MS = 5;
    localparam int HIST_20MS     = 20 / CYCLE_TIME_MS;
    localparam int HIST_200MS    = 200 / CYCLE_TIME_MS;
    localparam logic [31:0] MAX_TIME_MS = 32'h001B_7740;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_NEG_SET   = 8'h04;
    localparam logic [7:0] REG_RATIO_SET = 8'h08;
    localparam logic [7:0] REG_MIN_LOAD  = 8'h0C;
    localparam logic [7:0] REG_DELAY     = 8'h10;
    localparam logic [7:0] REG_CURVE_K   = 8'h14;
    localparam logic [7:0] REG_EV_MASK   = 8'h18;
    localparam logic [7:0] REG_CNT_CLR   = 8'h1C;
    localparam logic [7:0] REG_STATUS    = 8'h20;
    localparam logic [7:0] REG_SEQ_RATIO = 8'h24;
    localparam logic [7:0] REG_MEAS_RAT  = 8'h28;
    localparam logic [7:0] REG_EXPECT    = 8'h2C;
    localparam logic [7:0] REG_REMAIN    = 8'h30;
    localparam logic [7:0] REG_CNT_START = 8'h34;
    localparam logic [7:0] REG_CNT_TRIP  = 8'h38;
    localparam logic [7:0] REG_CNT_BLOCK = 8'h3C;
    localparam logic [7:0] REG_REC_SEL   = 8'h40;
    localparam logic [7:0] REG_REC_BASE  = 8'h48;
    localparam logic [7:0] REG_REC_END   = 8'h64;
    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_FORCE_LSB = 1;
    localparam int CTRL_FORCE_EN  = 3;
    localparam int CTRL_TMODE_LSB = 4;
    localparam logic [15:0] NEG_SET_RST   = 16'h0014;
    localparam logic [15:0] RATIO_SET_RST = 16'h07D0;
    localparam logic [15:0] MIN_LOAD_RST  = 16'h000A;
    localparam logic [31:0] DELAY_RST     = 32'h0000_0064;
    localparam logic [31:0] CURVE_K_RST   = 32'h0000_2710;
    localparam logic [5:0]  EV_MASK_RST   = 6'h3F;
    localparam logic [47:0] RELEASE_PCT   = 48'h0000_0000_0061;
    localparam logic [47:0] FULL_PCT      = 48'h0000_0000_0064;
    localparam logic [47:0] RATIO_SCALE   = 48'h0000_0000_2710;
    localparam int REC_DEPTH = 12;
    localparam int REC_WORDS = 8;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        ST_NORMAL  = 2'b00,
        ST_START   = 2'b01,
        ST_TRIP    = 2'b10,
        ST_BLOCKED = 2'b11
    } ubp_state_type;
    typedef enum logic [1:0] {
        TM_INSTANT  = 2'b00,
        TM_DEFINITE = 2'b01,
        TM_SQUARED  = 2'b10,
        TM_INVERSE  = 2'b11
    } ubp_tmode_type;
endpackage : ubp_pkg

// >>> src/ubp_unbalance_stage.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module ubp_unbalance_stage #(
    parameter int CYCLE_CLKS_P = ubp_pkg::CYCLE_CLKS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Measurement front end
    input  wire logic [15:0] pos_seq_magnitude,
    input  wire logic [15:0] neg_seq_magnitude,
    input  wire logic [15:0] zero_seq_magnitude,
    input  wire logic [15:0] pos_seq_angle,
    input  wire logic [15:0] neg_seq_angle,
    input  wire logic [15:0] zero_seq_angle,
    input  wire logic [15:0] phase_a_fund,
    input  wire logic [15:0] phase_b_fund,
    input  wire logic [15:0] phase_c_fund,
    // System context
    input  wire logic        block_in,
    input  wire logic [2:0]  setting_group,
    input  wire logic [31:0] time_stamp,
    input  wire logic [1:0]  stage_id,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rdata,
    // Stage outputs
    output logic             start_out,
    output logic             trip_out,
    output logic             blocked_out,
    // Event stream
    output logic             ev_valid,
    output logic      [5:0]  ev_flags,
    output logic      [1:0]  ev_stage,
    output logic      [31:0] ev_stamp
);
    import ubp_pkg::*;

    // ****************************************
    // Settings
    // ****************************************
    logic [6:0]  ctrl;
    logic [15:0] neg_seq_pickup_level;
    logic [15:0] seq_ratio_pickup_level;
    logic [15:0] min_load;
    logic [31:0] delay_ms;
    logic [31:0] curve_k;
    logic [5:0]  ev_mask;
    logic [3:0]  rec_sel;
    logic        seq_ratio_mode;
    logic [2:0]  cnt_clr;

    assign seq_ratio_mode = ctrl[CTRL_MODE_BIT];
    assign cnt_clr = (wr_en && addr == REG_CNT_CLR) ? wdata[2:0] : 3'h0;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl                   <= 7'h00;
            neg_seq_pickup_level   <= NEG_SET_RST;
            seq_ratio_pickup_level <= RATIO_SET_RST;
            min_load               <= MIN_LOAD_RST;
            delay_ms               <= DELAY_RST;
            curve_k                <= CURVE_K_RST;
            ev_mask                <= EV_MASK_RST;
            rec_sel                <= 4'h0;
        end else if (wr_en) begin
            // Levels and delays take effect at the next evaluation
            case (addr)
                REG_CTRL:      ctrl                   <= wdata[6:0];
                REG_NEG_SET:   neg_seq_pickup_level   <= wdata[15:0];
                REG_RATIO_SET: seq_ratio_pickup_level <= wdata[15:0];
                REG_MIN_LOAD:  min_load               <= wdata[15:0];
                REG_DELAY:     delay_ms               <= wdata;
                REG_CURVE_K:   curve_k                <= wdata;
                REG_EV_MASK:   ev_mask                <= wdata[5:0];
                REG_REC_SEL:   rec_sel                <= wdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Program cycle strobe and input latch
    // ****************************************
    logic [31:0] cyc_cnt;
    logic        strobe;
    logic        eval;
    logic [15:0] m_i1, m_i2, m_iz, m_a1, m_a2, m_az, m_pa, m_pb, m_pc;
    logic        blk;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cyc_cnt <= 32'h0;
            strobe  <= 1'b0;
            eval    <= 1'b0;
        end else begin
            strobe  <= (cyc_cnt == 32'(CYCLE_CLKS_P - 1));
            cyc_cnt <= (cyc_cnt == 32'(CYCLE_CLKS_P - 1)) ? 32'h0 : cyc_cnt + 32'h1;
            eval    <= strobe;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {m_i1, m_i2, m_iz, m_a1, m_a2, m_az, m_pa, m_pb, m_pc} <= '0;
            blk <= 1'b0;
        end else if (strobe) begin
            m_i1 <= pos_seq_magnitude;
            m_i2 <= neg_seq_magnitude;
            m_iz <= zero_seq_magnitude;
            m_a1 <= pos_seq_angle;
            m_a2 <= neg_seq_angle;
            m_az <= zero_seq_angle;
            m_pa <= phase_a_fund;
            m_pb <= phase_b_fund;
            m_pc <= phase_c_fund;
            blk  <= block_in;
        end
    end

    // ****************************************
    // Pick-up comparison
    // ****************************************
    // Cross-multiplied so no divider sits in the decision path
    logic [47:0] lhs_on, rhs_on, lhs_off, rhs_off;
    logic        load_ok, above, below;

    assign load_ok = (m_pa >= min_load) && (m_pb >= min_load) && (m_pc >= min_load);
    always_comb begin
        if (seq_ratio_mode) begin
            lhs_on  = {32'h0, m_i2} * RATIO_SCALE;
            rhs_on  = {32'h0, seq_ratio_pickup_level} * {32'h0, m_i1};
        end else begin
            lhs_on  = {32'h0, m_i2};
            rhs_on  = {32'h0, neg_seq_pickup_level};
        end
        lhs_off = 48'(lhs_on * FULL_PCT);
        rhs_off = 48'(rhs_on * RELEASE_PCT);
    end
    assign above = (lhs_on > rhs_on) && (!seq_ratio_mode || load_ok);
    assign below = (lhs_off < rhs_off) || (seq_ratio_mode && !load_ok);

    // ****************************************
    // Shared serial divider
    // ****************************************
    // One divider for three quotients trades latency for area
    logic [31:0] dv_num, dv_den, dv_quo;
    logic [32:0] dv_rem, rem_sh;
    logic [5:0]  dv_bit;
    logic [1:0]  dv_job;
    logic        dv_busy;
    logic [31:0] seq_ratio, meas_ratio, curve_ms;
    logic [15:0] q_meas, q_set;
    logic [31:0] sq_diff;

    assign q_meas  = seq_ratio_mode ? seq_ratio[15:0] : m_i2;
    assign q_set   = seq_ratio_mode ? seq_ratio_pickup_level : neg_seq_pickup_level;
    assign sq_diff = (q_meas > q_set) ? (q_meas * q_meas) - (q_set * q_set) : 32'h0;
    assign rem_sh  = {dv_rem[31:0], dv_num[31]};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dv_num <= 32'h0; dv_den <= 32'h0; dv_quo <= 32'h0; dv_rem <= 33'h0;
            dv_bit <= 6'h0;  dv_job <= 2'h0;  dv_busy <= 1'b0;
            seq_ratio <= 32'h0; meas_ratio <= 32'h0; curve_ms <= MAX_TIME_MS;
        end else if (eval) begin
            dv_num  <= 32'(m_i2 * 32'h2710);
            dv_den  <= {16'h0, m_i1};
            dv_rem  <= 33'h0; dv_quo <= 32'h0;
            dv_bit  <= 6'h0;  dv_job <= 2'h0; dv_busy <= 1'b1;
        end else if (dv_busy) begin
            if (rem_sh >= {1'b0, dv_den}) begin
                dv_rem <= rem_sh - {1'b0, dv_den};
                dv_quo <= {dv_quo[30:0], 1'b1};
            end else begin
                dv_rem <= rem_sh;
                dv_quo <= {dv_quo[30:0], 1'b0};
            end
            dv_num <= {dv_num[30:0], 1'b0};
            dv_bit <= dv_bit + 6'h1;
            if (dv_bit == 6'd32) begin
                dv_rem <= 33'h0; dv_quo <= 32'h0; dv_bit <= 6'h0;
                case (dv_job)
                    2'h0: begin
                        seq_ratio <= dv_quo;
                        dv_num    <= 32'((seq_ratio_mode ? dv_quo[15:0] : m_i2) * 32'h64);
                        dv_den    <= {16'h0, q_set};
                        dv_job    <= 2'h1;
                    end
                    2'h1: begin
                        meas_ratio <= dv_quo;
                        dv_num     <= curve_k;
                        dv_den     <= sq_diff;
                        dv_job     <= 2'h2;
                    end
                    default: begin
                        curve_ms <= (sq_diff == 32'h0 || dv_quo > MAX_TIME_MS) ?
                                    MAX_TIME_MS : dv_quo;
                        dv_busy  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Stage state machine and timing
    // ****************************************
    ubp_state_type state, next_state;
    logic          pick, next_pick, blk_latch;
    logic [31:0]   elapsed, expect_ms, remain_ms, next_elapsed;
    ubp_tmode_type tmode;

    assign tmode = ubp_tmode_type'(ctrl[CTRL_TMODE_LSB +: 2]);
    always_comb begin
        case (tmode)
            TM_INSTANT:  expect_ms = 32'h0;
            TM_DEFINITE: expect_ms = delay_ms;
            default:     expect_ms = curve_ms;
        endcase
    end
    assign next_pick = pick ? !below : above;

    always_comb begin
        next_state   = state;
        next_elapsed = elapsed;
        if (ctrl[CTRL_FORCE_EN]) begin
            next_state   = ubp_state_type'(ctrl[CTRL_FORCE_LSB +: 2]);
        end else if (!next_pick) begin
            next_state   = ST_NORMAL;
            next_elapsed = 32'h0;
        end else if (blk || state == ST_BLOCKED) begin
            next_state   = ST_BLOCKED;
            next_elapsed = 32'h0;
        end else if (state == ST_NORMAL) begin
            next_state   = (expect_ms == 32'h0) ? ST_TRIP : ST_START;
            next_elapsed = 32'h0;
        end else if (state == ST_START) begin
            next_elapsed = elapsed + 32'(CYCLE_TIME_MS);
            if (next_elapsed >= expect_ms) begin
                next_state = ST_TRIP;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state     <= ST_NORMAL;
            pick      <= 1'b0;
            elapsed   <= 32'h0;
            remain_ms <= 32'h0;
            blk_latch <= 1'b0;
        end else if (eval) begin
            // Blocked persists until pick-up releases
            state     <= next_state;
            pick      <= next_pick;
            elapsed   <= next_elapsed;
            remain_ms <= expect_ms - next_elapsed;
            blk_latch <= blk;
        end
    end

    // ****************************************
    // Outputs and events
    // ****************************************
    logic       st_on, tr_on, bl_on;
    logic [5:0] raw_ev;

    assign st_on  = (next_state == ST_START) || (next_state == ST_TRIP);
    assign tr_on  = (next_state == ST_TRIP);
    assign bl_on  = (next_state == ST_BLOCKED);
    assign raw_ev = {!bl_on && blocked_out, bl_on && !blocked_out,
                     !tr_on && trip_out,    tr_on && !trip_out,
                     !st_on && start_out,   st_on && !start_out};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            start_out <= 1'b0; trip_out <= 1'b0; blocked_out <= 1'b0;
            ev_valid  <= 1'b0; ev_flags <= 6'h0; ev_stage <= 2'h0; ev_stamp <= 32'h0;
        end else begin
            ev_valid <= 1'b0;
            if (eval) begin
                start_out   <= st_on;
                trip_out    <= tr_on;
                blocked_out <= bl_on;
                ev_valid    <= |(raw_ev & ev_mask);
                ev_flags    <= raw_ev & ev_mask;
                ev_stage    <= stage_id;
                ev_stamp    <= time_stamp;
            end
        end
    end

    // ****************************************
    // Counters
    // ****************************************
    logic [31:0] cnt [3];
    logic [2:0]  on_ev;

    assign on_ev = eval ? {raw_ev[4], raw_ev[2], raw_ev[0]} : 3'h0;
    for (genvar g = 0; g < 3; g++) begin : g_cnt
        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                cnt[g] <= 32'h0;
            end else if (on_ev[g]) begin
                // Event beats a clear in the same cycle
                cnt[g] <= cnt_clr[g] ? 32'h1 : cnt[g] + 32'h1;
            end else if (cnt_clr[g]) begin
                cnt[g] <= 32'h0;
            end
        end
    end

    // ****************************************
    // Current history and fault records
    // ****************************************
    logic [15:0]  hist [64];
    logic [5:0]   hptr;
    logic [255:0] rec_mem [REC_DEPTH];
    logic [3:0]   rec_ptr;
    logic [255:0] rec_new;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hptr <= 6'h0;
        end else if (eval) begin
            hist[hptr] <= m_i2;
            hptr       <= hptr + 6'h1;
        end
    end

    assign rec_new = {remain_ms, 16'h0, m_az, m_a1, m_a2, 16'h0, m_iz, m_i1, m_i2,
                      hist[6'(hptr - 6'(HIST_200MS))], hist[6'(hptr - 6'(HIST_20MS))],
                      time_stamp, 23'h0, setting_group, raw_ev};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rec_ptr <= 4'h0;
        end else if (|on_ev) begin
            rec_mem[rec_ptr] <= rec_new;
            rec_ptr <= (rec_ptr == 4'(REC_DEPTH - 1)) ? 4'h0 : rec_ptr + 4'h1;
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    logic [31:0] next_rdata;
    logic [2:0]  rec_word;
    logic [3:0]  rec_idx;

    assign rec_word = 3'((addr - REG_REC_BASE) >> 2);
    assign rec_idx  = (rec_sel < 4'(REC_DEPTH)) ? rec_sel : 4'h0;
    always_comb begin
        case (addr)
            REG_CTRL:      next_rdata = {25'h0, ctrl};
            REG_NEG_SET:   next_rdata = {16'h0, neg_seq_pickup_level};
            REG_RATIO_SET: next_rdata = {16'h0, seq_ratio_pickup_level};
            REG_MIN_LOAD:  next_rdata = {16'h0, min_load};
            REG_DELAY:     next_rdata = delay_ms;
            REG_CURVE_K:   next_rdata = curve_k;
            REG_EV_MASK:   next_rdata = {26'h0, ev_mask};
            REG_STATUS:    next_rdata = {28'h0, blk_latch, pick, state};
            REG_SEQ_RATIO: next_rdata = seq_ratio;
            REG_MEAS_RAT:  next_rdata = meas_ratio;
            REG_EXPECT:    next_rdata = expect_ms;
            REG_REMAIN:    next_rdata = remain_ms;
            REG_CNT_START: next_rdata = cnt[0];
            REG_CNT_TRIP:  next_rdata = cnt[1];
            REG_CNT_BLOCK: next_rdata = cnt[2];
            REG_REC_SEL:   next_rdata = {28'h0, rec_sel};
            default: begin
                if (addr >= REG_REC_BASE && addr <= REG_REC_END && addr[1:0] == 2'h0) begin
                    next_rdata = rec_mem[rec_idx][{rec_word, 5'h0} +: 32];
                end else begin
                    next_rdata = 32'h0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rd_en ? next_rdata : 32'h0;
        end
    end
endmodule : ubp_unbalance_stage

// >>> sim/ubp_asserts.sv
`timescale 1ns/1ps
// ****************
// Stage checker
// ****************
module ubp_asserts #(
    parameter int CYCLE_CLKS_P = 150
) (
    // Watched ports
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        block_in,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic        start_out,
    input wire logic        trip_out,
    input wire logic        blocked_out,
    input wire logic        ev_valid,
    input wire logic [5:0]  ev_flags,
    input wire logic [1:0]  ev_stage,
    input wire logic [31:0] ev_stamp,
    input wire logic [1:0]  stage_id,
    input wire logic [31:0] time_stamp
);
    // Two strobes of slack: block may land just after a strobe
    localparam int WIN = 2 * CYCLE_CLKS_P + 2;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_blk_late; start_out && $rose(block_in); endsequence
    sequence s_drop; !start_out || !block_in; endsequence
    property p_blk_drop; s_blk_late |-> ##[1:WIN] s_drop; endproperty
    property p_trip_start; trip_out |-> start_out; endproperty
    property p_blk_excl; blocked_out |-> !start_out && !trip_out; endproperty
    property p_hold;
        $changed({start_out, trip_out, blocked_out}) |=>
            $stable({start_out, trip_out, blocked_out}) [*8];
    endproperty
    property p_ev_pulse; ev_valid |=> !ev_valid; endproperty
    property p_start_ev; $rose(start_out) |-> ev_valid && ev_flags[0]; endproperty
    property p_start_off; $fell(start_out) |-> ev_valid && ev_flags[1]; endproperty
    property p_trip_ev; $rose(trip_out) |-> ev_valid && ev_flags[2]; endproperty
    property p_rd_idle; !$past(rd_en) |-> rdata == 32'h0; endproperty
    property p_blk_ev; $rose(blocked_out) |-> ev_valid && ev_flags[4]; endproperty
    // Stage and stamp are copied at the evaluating edge
    property p_ev_tag;
        ev_valid |-> ev_stage == $past(stage_id) && ev_stamp == $past(time_stamp);
    endproperty
    a_blk_drop: assert property (p_blk_drop) else $error("start held under block");
    a_trip_start: assert property (p_trip_start) else $error("trip without start");
    a_blk_excl: assert property (p_blk_excl) else $error("blocked with start");
    a_hold: assert property (p_hold) else $error("outputs moved off strobe");
    a_ev_pulse: assert property (p_ev_pulse) else $error("event pulse too long");
    a_start_ev: assert property (p_start_ev) else $error("no start on event");
    a_start_off: assert property (p_start_off) else $error("no start off event");
    a_trip_ev: assert property (p_trip_ev) else $error("no trip on event");
    a_blk_ev: assert property (p_blk_ev) else $error("no block on event");
    a_ev_tag: assert property (p_ev_tag) else $error("bad event tag");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : ubp_asserts

bind ubp_unbalance_stage ubp_asserts #(.CYCLE_CLKS_P(CYCLE_CLKS_P)) u_chk (
    .clk_sys, .rst_n, .block_in, .rd_en, .rdata, .start_out, .trip_out,
    .blocked_out, .ev_valid, .ev_flags, .ev_stage, .ev_stamp, .stage_id, .time_stamp);

// >>> sim/ubp_front_end.sv
`timescale 1ns/1ps
// ****************
// Front end model
// ****************
module ubp_front_end (
    // Clock and commands
    input  wire logic        clk_sys,
    input  wire logic [15:0] neg_cmd,
    input  wire logic [15:0] ph_cmd,
    input  wire logic        blk_cmd,
    // Sequence values
    output logic      [15:0] pos_seq_magnitude,
    output logic      [15:0] neg_seq_magnitude,
    output logic      [15:0] zero_seq_magnitude,
    output logic      [15:0] pos_seq_angle,
    output logic      [15:0] neg_seq_angle,
    output logic      [15:0] zero_seq_angle,
    // Phase values and context
    output logic      [15:0] phase_a_fund,
    output logic      [15:0] phase_b_fund,
    output logic      [15:0] phase_c_fund,
    output logic             block_in,
    output logic      [31:0] time_stamp
);
    logic [31:0] ts = 32'h0;
    always @(posedge clk_sys) ts <= ts + 32'h1;
    // Magnitudes and phase values stay put between bench updates, as a 5 ms feed would; two angles follow ts each clock
    assign pos_seq_magnitude  = 16'h0064;
    assign neg_seq_magnitude  = neg_cmd;
    assign zero_seq_magnitude = neg_cmd >> 1;
    assign pos_seq_angle      = ts[15:0];
    assign neg_seq_angle      = ~ts[15:0];
    assign zero_seq_angle     = 16'h005A;
    assign phase_a_fund       = ph_cmd;
    assign phase_b_fund       = ph_cmd;
    assign phase_c_fund       = ph_cmd;
    // Bench raises block whole periods before the delay runs out
    assign block_in           = blk_cmd;
    assign time_stamp         = ts;
endmodule : ubp_front_end

// >>> sim/test_current_unbalance_protection_stage.sv
`timescale 1ns/1ps
// ****************
// Stage testbench
// ****************
module test_current_unbalance_protection_stage;
    import ubp_pkg::*;
    localparam int CY = 150;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] neg_cmd = 16'h0000;
    logic [15:0] ph_cmd = 16'h0064;
    logic        blk_cmd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    int          error_cnt = 0;
    int          n_checks = 0;
    wire logic [15:0] pos_seq_magnitude, neg_seq_magnitude, zero_seq_magnitude;
    wire logic [15:0] pos_seq_angle, neg_seq_angle, zero_seq_angle;
    wire logic [15:0] phase_a_fund, phase_b_fund, phase_c_fund;
    wire logic [31:0] time_stamp, rdata;
    wire logic        block_in, start_out, trip_out, blocked_out;
    // Row: ctrl, neg, phase, block nibble, {blocked, start, trip}
    logic [31:0] rows [10] = '{32'h0015_6403, 32'h0014_6403, 32'h0013_6400,
        32'h0015_6414, 32'h0000_6400, 32'h011E_6403, 32'h011E_0500,
        32'h010A_6400, 32'h0E00_6404, 32'h0600_6400};
    always #12.5 clk_sys = ~clk_sys;
    ubp_front_end u_fe (.clk_sys, .neg_cmd, .ph_cmd, .blk_cmd, .pos_seq_magnitude,
        .neg_seq_magnitude, .zero_seq_magnitude, .pos_seq_angle, .neg_seq_angle,
        .zero_seq_angle, .phase_a_fund, .phase_b_fund, .phase_c_fund, .block_in,
        .time_stamp);
    ubp_unbalance_stage #(.CYCLE_CLKS_P(CY)) uut (.clk_sys, .rst_n, .pos_seq_magnitude,
        .neg_seq_magnitude, .zero_seq_magnitude, .pos_seq_angle, .neg_seq_angle,
        .zero_seq_angle, .phase_a_fund, .phase_b_fund, .phase_c_fund, .block_in,
        .setting_group(3'h1), .time_stamp, .stage_id(2'h2), .addr, .wdata, .wr_en,
        .rd_en, .rdata, .start_out, .trip_out, .blocked_out, .ev_valid(),
        .ev_flags(), .ev_stage(), .ev_stamp());
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic per(input int n);
        repeat (n * CY) @(posedge clk_sys);
    endtask : per
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
        @(posedge clk_sys);
    endtask : rd
    task automatic outs(input logic [2:0] exp);
        #1;
        chk({29'h0, blocked_out, start_out, trip_out}, {29'h0, exp});
        @(posedge clk_sys);
    endtask : outs
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(REG_CTRL, {24'h0, rows[i][31:24]});
            neg_cmd <= {8'h00, rows[i][23:16]};
            ph_cmd <= {8'h00, rows[i][15:8]};
            blk_cmd <= rows[i][4];
            per(3);
            outs(rows[i][2:0]);
        end
        $display("table test done");
        rd(REG_NEG_SET, {16'h0, NEG_SET_RST});
        rd(REG_RATIO_SET, {16'h0, RATIO_SET_RST});
        rd(8'hFC, 32'h0);
        rd(REG_REC_BASE, 32'h0000_0045);
        rd(8'h54, 32'h0064_0015);
        $display("reset value test done");
        wr(REG_CNT_CLR, 32'h7);
        wr(REG_DELAY, 32'h28);
        wr(REG_CTRL, 32'h10);
        neg_cmd <= 16'h001E;
        per(3);
        outs(3'b010);
        per(9);
        outs(3'b011);
        rd(REG_SEQ_RATIO, 32'h0000_0BB8);
        rd(REG_MEAS_RAT, 32'h0000_0096);
        wr(REG_CTRL, 32'h20);
        per(3);
        rd(REG_EXPECT, 32'h14);
        $display("delay test done");
        neg_cmd <= 16'h0000;
        per(3);
        wr(REG_CTRL, 32'h10);
        neg_cmd <= 16'h001E;
        per(3);
        blk_cmd <= 1'b1;
        per(3);
        outs(3'b100);
        rd(REG_STATUS, 32'h0000_000F);
        blk_cmd <= 1'b0;
        neg_cmd <= 16'h0000;
        per(3);
        rd(REG_CNT_START, 32'h2);
        rd(REG_CNT_TRIP, 32'h1);
        rd(REG_CNT_BLOCK, 32'h1);
        $display("block and counter test done");
        test_done();
    end
endmodule : test_current_unbalance_protection_stage
